// ### rtl/amsc_consts.vh
`ifndef AMSC_CONSTS_VH
`define AMSC_CONSTS_VH

// clock rate
`define AMSC_CLK_MHZ          40
`define AMSC_CLK_PERIOD_NS    25

// timing figures in their own units
`define AMSC_SW_MAX_NS        500
`define AMSC_DEBOUNCE_MIN_US  2000
`define AMSC_DEBOUNCE_MAX_US  10000
`define AMSC_OVERLAP_MIN_US   4
`define AMSC_OVERLAP_CYC      20'h000a0 // 4 us at 25 ns per cycle
`define AMSC_RXDET_INTVL_US   12000
`define AMSC_RXDET_WAIT_CYC   20'h00010
`define AMSC_STRAP_CYC        2'h3

// register byte offsets
`define AMSC_CTRL_OFS         8'h00
`define AMSC_STATUS_OFS       8'h04

// control register fields
`define AMSC_CTRL_EQ_OVR_BIT  0
`define AMSC_CTRL_UP_LSB      2
`define AMSC_CTRL_DOWN_LSB    4
`define AMSC_CTRL_DISP_LSB    6
`define AMSC_CTRL_RESET       8'h00

// status register fields
`define AMSC_STAT_MODE_LSB    0
`define AMSC_STAT_FLIP_BIT    2
`define AMSC_STAT_DE_BIT      3
`define AMSC_STAT_HPD_BIT     4
`define AMSC_STAT_SW_BIT      5
`define AMSC_STAT_TERM_BIT    6
`define AMSC_STAT_HOLD_BIT    7
`define AMSC_STAT_OVL_BIT     8

// operating modes
`define AMSC_MODE_OFF         2'h0
`define AMSC_MODE_USB         2'h1
`define AMSC_MODE_DP4         2'h2
`define AMSC_MODE_USB_DP2     2'h3

`endif

// ### rtl/amsc_top.v
// Contract
// - open aux switch within 500 ns after debounce
// - close aux switch within 500 ns
// - debounce falling enable and hot-plug 2-10 ms
// - periodic receiver detection on transmit pairs
// - receiver found enables termination and redrive
// - per-group equalization from own select pins
// - start in usb-only, leave on select pulse
// - decode mode from display enable and usb select pins, orientation picks aux routing and the flip output, not the mode
// - route aux to sideband by orientation
`timescale 1ns/10ps
`include "amsc_consts.vh"

module amsc_debounce #(
    parameter DEB_CYC = 80000
) (
    input  wire clock,
    input  wire rst_int_n,
    input  wire level_in,
    output reg  level_ff
);
    reg [19:0] cnt_ff;

    // rising follows at once, falling waits a full quiet interval
    always @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            cnt_ff   <= 20'h00000;
            level_ff <= 1'b0;
        end else if (level_in) begin
            cnt_ff   <= 20'h00000;
            level_ff <= 1'b1;
        end else if (level_ff) begin
            if (cnt_ff >= DEB_CYC[19:0] - 20'h00001) begin
                cnt_ff   <= 20'h00000;
                level_ff <= 1'b0;
            end else begin
                cnt_ff <= cnt_ff + 20'h00001;
            end
        end
    end
endmodule // amsc_debounce

module amsc_top #(
    parameter DEBOUNCE_CYC = `AMSC_DEBOUNCE_MIN_US * `AMSC_CLK_MHZ,
    parameter RXDET_CYC    = `AMSC_RXDET_INTVL_US * `AMSC_CLK_MHZ
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        display_enable_pin,
    input  wire        usb_select_pin,
    input  wire        orientation_pin,
    input  wire        hot_plug_input,
    input  wire        rx_detect_found,
    input  wire [1:0]  usb_up_eq_select,
    input  wire [1:0]  usb_down_eq_select,
    input  wire [1:0]  display_eq_select,
    output reg         aux_straight_on_ff,
    output reg         aux_cross_on_ff,
    output reg  [1:0]  mode_ff,
    output reg         flip_ff,
    output reg         power_down_ff,
    output reg         rx_detect_start_ff,
    output reg         rx_term_en_ff,
    output reg         redrive_active_ff,
    output reg  [1:0]  usb_up_eq_ff,
    output reg  [1:0]  usb_down_eq_ff,
    output reg  [1:0]  display_eq_ff,
    output wire        hot_plug_db
);
    localparam [19:0] OVERLAP_CYC = `AMSC_OVERLAP_CYC;
    localparam [1:0]  RX_IDLE     = 2'h0;
    localparam [1:0]  RX_DETECT   = 2'h1;
    localparam [1:0]  RX_ACTIVE   = 2'h2;

    reg         rst_s1_ff;
    reg         rst_int_n;
    reg  [6:0]  sync1_ff;
    reg  [6:0]  sync2_ff;
    reg  [5:0]  eq1_ff;
    reg  [5:0]  eq2_ff;
    reg  [5:0]  strap_eq_ff;
    reg  [1:0]  strap_cnt_ff;
    reg  [7:0]  ctrl_ff;
    reg         usb_hold_ff;
    reg         usb_prev_ff;
    reg         ovl_err_ff;
    reg  [19:0] ovl_cnt_ff;
    reg  [1:0]  rx_state_ff;
    reg  [19:0] rx_cnt_ff;
    reg  [1:0]  nxt_mode;
    reg  [31:0] nxt_rdata;
    reg         nxt_err;
    wire        de_s;
    wire        usb_s;
    wire        flip_s;
    wire        hpd_s;
    wire        found_s;
    wire        de_db;
    wire        usb_fall;
    wire        usb_path;
    wire        wr_en;
    wire        rd_phase;

    // reset release through two flops
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_int_n <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_int_n <= rst_s1_ff;
        end
    end

    // two-flop synchronisers for all pins
    always @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            sync1_ff <= 7'h00;
            sync2_ff <= 7'h00;
            eq1_ff   <= 6'h00;
            eq2_ff   <= 6'h00;
        end else begin
            sync1_ff <= {rx_detect_found, hot_plug_input, orientation_pin, usb_select_pin, display_enable_pin, 2'h0};
            sync2_ff <= sync1_ff;
            eq1_ff   <= {display_eq_select, usb_down_eq_select, usb_up_eq_select};
            eq2_ff   <= eq1_ff;
        end
    end

    assign de_s    = sync2_ff[2];
    assign usb_s   = sync2_ff[3];
    assign flip_s  = sync2_ff[4];
    assign hpd_s   = sync2_ff[5];
    assign found_s = sync2_ff[6];

    // falling-edge filters on display enable and hot plug
    amsc_debounce #(.DEB_CYC(DEBOUNCE_CYC)) u_de_deb (
        .clock     (clock),
        .rst_int_n (rst_int_n),
        .level_in  (de_s),
        .level_ff  (de_db)
    );
    amsc_debounce #(.DEB_CYC(DEBOUNCE_CYC)) u_hpd_deb (
        .clock     (clock),
        .rst_int_n (rst_int_n),
        .level_in  (hpd_s),
        .level_ff  (hot_plug_db)
    );

    // equalization straps caught once synchronised pins have settled
    always @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            strap_cnt_ff <= 2'h0;
            strap_eq_ff  <= 6'h00;
        end else if (strap_cnt_ff != `AMSC_STRAP_CYC) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            strap_eq_ff  <= eq2_ff;
        end
    end

    // each group gets its own gain, pin strap or software override
    always @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            usb_up_eq_ff   <= 2'h0;
            usb_down_eq_ff <= 2'h0;
            display_eq_ff  <= 2'h0;
        end else if (ctrl_ff[`AMSC_CTRL_EQ_OVR_BIT]) begin
            usb_up_eq_ff   <= ctrl_ff[`AMSC_CTRL_UP_LSB +: 2];
            usb_down_eq_ff <= ctrl_ff[`AMSC_CTRL_DOWN_LSB +: 2];
            display_eq_ff  <= ctrl_ff[`AMSC_CTRL_DISP_LSB +: 2];
        end else begin
            usb_up_eq_ff   <= strap_eq_ff[1:0];
            usb_down_eq_ff <= strap_eq_ff[3:2];
            display_eq_ff  <= strap_eq_ff[5:4];
        end
    end

    assign usb_fall = usb_prev_ff & ~usb_s;

    // usb-only hold after power-up, cleared by a select pulse
    always @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            usb_prev_ff <= 1'b0;
            usb_hold_ff <= 1'b1;
        end else begin
            usb_prev_ff <= usb_s;
            if (usb_fall) begin
                usb_hold_ff <= 1'b0;
            end
        end
    end

    // mode decode from configuration pins
    always @* begin
        case ({de_db, usb_s})
            2'b00:   nxt_mode = usb_hold_ff ? `AMSC_MODE_USB : `AMSC_MODE_OFF;
            2'b01:   nxt_mode = `AMSC_MODE_USB;
            2'b10:   nxt_mode = `AMSC_MODE_DP4;
            default: nxt_mode = `AMSC_MODE_USB_DP2;
        endcase
    end

    // mode, orientation and aux switch registers
    always @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            mode_ff            <= `AMSC_MODE_USB;
            flip_ff            <= 1'b0;
            power_down_ff      <= 1'b0;
            aux_straight_on_ff <= 1'b0;
            aux_cross_on_ff    <= 1'b0;
        end else begin
            mode_ff            <= nxt_mode;
            flip_ff            <= flip_s;
            power_down_ff      <= (nxt_mode == `AMSC_MODE_OFF);
            aux_straight_on_ff <= de_db & ~flip_s;
            aux_cross_on_ff    <= de_db & flip_s;
        end
    end

    // watch overlap of both pins before usb select drops
    always @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            ovl_cnt_ff <= 20'h00000;
            ovl_err_ff <= 1'b0;
        end else begin
            if (de_s & usb_s) begin
                if (ovl_cnt_ff < OVERLAP_CYC) begin
                    ovl_cnt_ff <= ovl_cnt_ff + 20'h00001;
                end
            end else begin
                ovl_cnt_ff <= 20'h00000;
            end
            if (usb_fall && de_s && ovl_cnt_ff < OVERLAP_CYC) begin
                ovl_err_ff <= 1'b1;
            end else if (wr_en && paddr == `AMSC_STATUS_OFS && pwdata[`AMSC_STAT_OVL_BIT]) begin
                ovl_err_ff <= 1'b0;
            end
        end
    end

    assign usb_path = (mode_ff == `AMSC_MODE_USB) || (mode_ff == `AMSC_MODE_USB_DP2);

    // receiver detection loop
    always @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            rx_state_ff        <= RX_IDLE;
            rx_cnt_ff          <= 20'h00000;
            rx_detect_start_ff <= 1'b0;
            rx_term_en_ff      <= 1'b0;
            redrive_active_ff  <= 1'b0;
        end else begin
            rx_detect_start_ff <= 1'b0;
            case (rx_state_ff)
                RX_IDLE: begin
                    if (!usb_path) begin
                        rx_cnt_ff <= 20'h00000;
                    end else if (rx_cnt_ff >= RXDET_CYC[19:0] - 20'h00001) begin
                        rx_cnt_ff          <= 20'h00000;
                        rx_detect_start_ff <= 1'b1;
                        rx_state_ff        <= RX_DETECT;
                    end else begin
                        rx_cnt_ff <= rx_cnt_ff + 20'h00001;
                    end
                end
                RX_DETECT: begin
                    if (found_s && usb_path) begin
                        rx_cnt_ff         <= 20'h00000;
                        rx_term_en_ff     <= 1'b1;
                        redrive_active_ff <= 1'b1;
                        rx_state_ff       <= RX_ACTIVE;
                    end else if (!usb_path || rx_cnt_ff >= `AMSC_RXDET_WAIT_CYC) begin
                        rx_cnt_ff   <= 20'h00000;
                        rx_state_ff <= RX_IDLE;
                    end else begin
                        rx_cnt_ff <= rx_cnt_ff + 20'h00001;
                    end
                end
                RX_ACTIVE: begin
                    if (!found_s || !usb_path) begin
                        rx_term_en_ff     <= 1'b0;
                        redrive_active_ff <= 1'b0;
                        rx_state_ff       <= RX_IDLE;
                    end
                end
                default: rx_state_ff <= RX_IDLE;
            endcase
        end
    end

    // apb: one wait state, write lands on the pready edge
    assign rd_phase = psel & penable & ~pready;
    assign wr_en    = psel & penable & pready & pwrite;
    // read data and error flag of the addressed word
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err   = 1'b0;
        if (paddr == `AMSC_CTRL_OFS) begin
            nxt_rdata[7:0] = ctrl_ff;
        end else if (paddr == `AMSC_STATUS_OFS) begin
            nxt_rdata[`AMSC_STAT_MODE_LSB +: 2] = mode_ff;
            nxt_rdata[`AMSC_STAT_FLIP_BIT]      = flip_ff;
            nxt_rdata[`AMSC_STAT_DE_BIT]        = de_db;
            nxt_rdata[`AMSC_STAT_HPD_BIT]       = hot_plug_db;
            nxt_rdata[`AMSC_STAT_SW_BIT]        = aux_straight_on_ff | aux_cross_on_ff;
            nxt_rdata[`AMSC_STAT_TERM_BIT]      = rx_term_en_ff;
            nxt_rdata[`AMSC_STAT_HOLD_BIT]      = usb_hold_ff;
            nxt_rdata[`AMSC_STAT_OVL_BIT]       = ovl_err_ff;
        end else begin
            nxt_err = 1'b1;
        end
    end
    // bus response and control word; read data is zero outside the response cycle
    always @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            ctrl_ff <= `AMSC_CTRL_RESET;
        end else begin
            pready  <= rd_phase;
            prdata  <= (rd_phase && !pwrite) ? nxt_rdata : 32'h00000000;
            pslverr <= rd_phase & nxt_err;
            if (wr_en && paddr == `AMSC_CTRL_OFS) begin
                ctrl_ff <= pwdata[7:0];
            end
        end
    end
endmodule // amsc_top

// ### bench/amsc_monitor.sv
`timescale 1ns/10ps
module amsc_monitor #(
    parameter DEBOUNCE_CYC = 20
) (
    input wire       clock,
    input wire       rst_n,
    input wire       display_enable_pin,
    input wire       usb_select_pin,
    input wire       rx_detect_found,
    input wire       aux_straight_on_ff,
    input wire       aux_cross_on_ff,
    input wire [1:0] mode_ff,
    input wire       flip_ff,
    input wire       rx_detect_start_ff,
    input wire       rx_term_en_ff,
    input wire       redrive_active_ff,
    input wire       pslverr
);
    localparam int SW_MAX = 20;
    logic        sw;
    logic [15:0] low_cnt_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    assign sw = aux_straight_on_ff | aux_cross_on_ff;
    // cycles the enable pin has stayed low
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) low_cnt_ff <= 16'h0000;
        else if (display_enable_pin) low_cnt_ff <= 16'h0000;
        else if (low_cnt_ff != 16'hffff) low_cnt_ff <= low_cnt_ff + 16'h0001;
    end
    property p_sw_on; $rose(display_enable_pin) |-> ##[1:SW_MAX] (sw || !display_enable_pin); endproperty
    property p_sw_off; low_cnt_ff == DEBOUNCE_CYC + 26 |-> !sw; endproperty
    property p_deb; $fell(sw) |-> low_cnt_ff >= DEBOUNCE_CYC; endproperty
    property p_excl; !(aux_straight_on_ff && aux_cross_on_ff); endproperty
    property p_rt_s; (!flip_ff)[*4] ##0 sw |-> aux_straight_on_ff; endproperty
    property p_rt_x; flip_ff[*4] ##0 sw |-> aux_cross_on_ff; endproperty
    property p_dp2; (display_enable_pin && usb_select_pin)[*8] |-> mode_ff == 2'h3; endproperty
    property p_dp4; (display_enable_pin && !usb_select_pin)[*8] |-> mode_ff == 2'h2; endproperty
    property p_rx;
        (rx_detect_start_ff && mode_ff == 2'h1) ##1 (rx_detect_found && mode_ff == 2'h1)[*8]
            |-> ##[0:16] (rx_term_en_ff && redrive_active_ff);
    endproperty
    a_sw_on: assert property (p_sw_on) else $error("switch slow to close");
    a_sw_off: assert property (p_sw_off) else $error("switch slow to open");
    a_deb: assert property (p_deb) else $error("switch opened inside debounce");
    a_excl: assert property (p_excl) else $error("both routings closed");
    a_rt_s: assert property (p_rt_s) else $error("wrong unflipped routing");
    a_rt_x: assert property (p_rt_x) else $error("wrong flipped routing");
    a_dp2: assert property (p_dp2) else $error("usb plus two lanes not decoded");
    a_dp4: assert property (p_dp4) else $error("four lanes not decoded");
    a_rx: assert property (p_rx) else $error("termination not enabled");
    c_cross: cover property (aux_cross_on_ff);
    c_term: cover property (rx_term_en_ff);
    c_err: cover property (pslverr);
endmodule // amsc_monitor

bind amsc_top amsc_monitor #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_amsc_monitor (
    .clock, .rst_n, .display_enable_pin, .usb_select_pin, .rx_detect_found,
    .aux_straight_on_ff, .aux_cross_on_ff, .mode_ff, .flip_ff, .rx_detect_start_ff,
    .rx_term_en_ff, .redrive_active_ff, .pslverr
);

// ### bench/amsc_ppc_model.sv
`timescale 1ns/10ps
module amsc_ppc_model (
    input  wire  clock,
    output logic display_enable_pin,
    output logic usb_select_pin,
    output logic orientation_pin
);
    // power up with usb only selected
    initial begin
        display_enable_pin = 1'b0;
        usb_select_pin = 1'b1;
        orientation_pin = 1'b0;
    end
    // drive all pins right after an edge
    task set_pins(input logic de, input logic us, input logic fl);
        @(posedge clock);
        display_enable_pin <= de;
        usb_select_pin <= us;
        orientation_pin <= fl;
    endtask
    // low-high-low pulse on usb select leaves usb-only
    task exit_usb();
        set_pins(1'b0, 1'b0, orientation_pin);
        repeat (4) @(posedge clock);
        set_pins(1'b0, 1'b1, orientation_pin);
        repeat (4) @(posedge clock);
        set_pins(1'b0, 1'b0, orientation_pin);
    endtask
    // both pins high for n+1 cycles before usb select drops
    task to_dp4(input int n, input logic fl);
        set_pins(1'b1, 1'b1, fl);
        repeat (n) @(posedge clock);
        set_pins(1'b1, 1'b0, fl);
    endtask
endmodule // amsc_ppc_model

// ### bench/alt_mode_switch_control_tb.sv
`timescale 1ns/10ps
module alt_mode_switch_control_tb;
    localparam DEB = 20;
    logic        clock = 1'b0;
    logic        rst_n, psel, penable, pwrite, er, hot_plug_input, rx_detect_found;
    logic [7:0]  paddr, ctrl_ref;
    logic [31:0] pwdata, wd, rd, seed;
    logic [1:0]  usb_up_eq_select, usb_down_eq_select, display_eq_select;
    wire  [31:0] prdata;
    wire         pready, pslverr, display_enable_pin, usb_select_pin, orientation_pin, hot_plug_db;
    wire         aux_straight_on_ff, aux_cross_on_ff, flip_ff, power_down_ff, rx_detect_start_ff;
    wire         rx_term_en_ff, redrive_active_ff;
    wire  [1:0]  mode_ff, usb_up_eq_ff, usb_down_eq_ff, display_eq_ff;
    int          errors, comparisons, n;
    int          cyc = 0;
    amsc_top #(.DEBOUNCE_CYC(DEB), .RXDET_CYC(50)) u_amsc_top (.*);
    amsc_ppc_model u_amsc_ppc_model (.*);
    always #12.5 clock = ~clock;
    // cut a hang short
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // reference decode of the configuration pins
    function automatic logic [1:0] exp_mode(input logic de, input logic us);
        return de ? (us ? 2'h3 : 2'h2) : {1'b0, us};
    endfunction
    task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one bus transfer; waits for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        if (w && a == 8'h00) ctrl_ref = d[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // cycles until the switch reaches level v
    task sw_wait(input logic v);
        n = 0;
        while ((aux_straight_on_ff | aux_cross_on_ff) !== v && n < 100) begin
            @(posedge clock);
            n++;
        end
    endtask
    task summarize();
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial begin
        errors = 0;
        comparisons = 0;
        {rst_n, psel, penable, pwrite, paddr, pwdata} = 44'h0;
        ctrl_ref = 8'h00;
        hot_plug_input = 1'b1;
        rx_detect_found = 1'b0;
        seed = lfsr(32'h4b90197a);
        {usb_up_eq_select, usb_down_eq_select, display_eq_select} = seed[5:0];
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        apb(1'b0, 8'h04, 32'h0);
        check("mode", rd[1:0], 2'h1);
        check("eq", {usb_up_eq_ff, usb_down_eq_ff, display_eq_ff}, seed[5:0]);
        // gain override by register, unmapped word
        seed = lfsr(seed);
        wd = {24'h0, seed[7:2], 2'h1};
        apb(1'b1, 8'h00, wd);
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl", rd, {24'h0, ctrl_ref});
        check("ovr_eq", {display_eq_ff, usb_down_eq_ff, usb_up_eq_ff}, ctrl_ref[7:2]);
        apb(1'b0, 8'h08, 32'h0);
        check("unmapped", {er, rd}, 33'h100000000);
        apb(1'b1, 8'h00, 32'h0);
        // periodic detection, receiver comes and goes
        n = 0;
        repeat (200) begin
            @(posedge clock);
            if (rx_detect_start_ff === 1'b1) n++;
        end
        check("rxdet", n >= 2, 1'b1);
        rx_detect_found <= 1'b1;
        repeat (150) @(posedge clock);
        check("term", {rx_term_en_ff, redrive_active_ff}, 2'h3);
        rx_detect_found <= 1'b0;
        repeat (10) @(posedge clock);
        check("term_off", {rx_term_en_ff, redrive_active_ff}, 2'h0);
        u_amsc_ppc_model.exit_usb();
        repeat (8) @(posedge clock);
        check("pd", {mode_ff, power_down_ff}, 3'h1);
        // closing time and routing, then a filtered and a real drop
        u_amsc_ppc_model.set_pins(1'b1, 1'b1, 1'b0);
        sw_wait(1'b1);
        check("on_time", n <= 20, 1'b1);
        check("route", {aux_straight_on_ff, aux_cross_on_ff}, 2'h2);
        check("dp2", mode_ff, exp_mode(1'b1, 1'b1));
        u_amsc_ppc_model.set_pins(1'b0, 1'b1, 1'b0);
        repeat (DEB - 4) @(posedge clock);
        u_amsc_ppc_model.set_pins(1'b1, 1'b1, 1'b0);
        repeat (30) @(posedge clock);
        check("glitch", aux_straight_on_ff, 1'b1);
        u_amsc_ppc_model.set_pins(1'b0, 1'b1, 1'b0);
        sw_wait(1'b0);
        check("off_time", n >= DEB && n <= DEB + 26, 1'b1);
        repeat (5) @(posedge clock);
        check("usb", mode_ff, exp_mode(1'b0, 1'b1));
        // usb-only to four flipped lanes, with a full and a too-short overlap
        u_amsc_ppc_model.to_dp4(160, 1'b1);
        repeat (8) @(posedge clock);
        apb(1'b0, 8'h04, 32'h0);
        check("dp4", rd[8:0], 9'h03e);
        check("cross", {aux_straight_on_ff, aux_cross_on_ff}, 2'h1);
        u_amsc_ppc_model.set_pins(1'b0, 1'b1, 1'b1);
        repeat (DEB + 30) @(posedge clock);
        u_amsc_ppc_model.to_dp4(10, 1'b1);
        repeat (8) @(posedge clock);
        apb(1'b0, 8'h04, 32'h0);
        check("ovl", rd[8], 1'b1);
        apb(1'b1, 8'h04, 32'h100);
        apb(1'b0, 8'h04, 32'h0);
        check("ovl_clr", rd[8], 1'b0);
        // hot plug short and long drops
        hot_plug_input <= 1'b0;
        repeat (DEB - 4) @(posedge clock);
        hot_plug_input <= 1'b1;
        repeat (30) @(posedge clock);
        check("hpd_glitch", hot_plug_db, 1'b1);
        hot_plug_input <= 1'b0;
        repeat (DEB - 2) @(posedge clock);
        check("hpd_hold", hot_plug_db, 1'b1);
        repeat (10) @(posedge clock);
        check("hpd_low", hot_plug_db, 1'b0);
        summarize();
    end
endmodule // alt_mode_switch_control_tb
